// ==== hw/omc_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "omc_map.svh"

// What this block does
// - Operation control bit 7 turns on oscillator and regulators and gives ready mode.
// - Reception is enabled only while operation control bit 6 is one.
// - Bit 5 picks both AM and PM channels when zero, or one channel chosen by the channel pick bit when one.
// - With both channels on, bit 4 zero means automatic best channel and one means manual pick.
// - Bit 3 enables transmit, is set by a field-on command and cleared after a transmission in active modes.
// - Bit 2 puts the device in wake-up mode under the wake-up timer settings.
// - Operation control resets to all zero only at power-up, never by a command.
// - Mode bit 7 selects initiator or target and changes how the protocol code is read.
// - The protocol code sits in mode bits 6 to 3 and resets to 0001.
// - Initiator codes select peer-to-peer, types A, B, F, type 1, sub-carrier and BPSK streams.
// - Target codes select peer-to-peer with rate detection or normal, others unused.
// - An unsupported role and code pair keeps transmit and receive disabled.
// - With mode bit 0 set, collision avoidance starts when the external field is seen going off.
// - Mode definition resets at power-up and on the set-default command.
module omc_ctrl (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // AXI4-Lite write address
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Events from the device core, same clock
    input wire logic TX_DONE,
    input wire logic EXT_FIELD_ON,
    input wire logic CHANNEL_PICK_BIT,
    // Control towards the front end
    output omc_pkg::omc_ctl_t CTL,
    output omc_pkg::omc_proto_t PROTO,
    output logic RX_USE_PM
);

    // Register state
    logic [7:0] op_reg, op_next;
    logic [7:0] md_reg, md_next;

    // Write channel state
    logic aw_got_reg, aw_got_next;
    logic w_got_reg, w_got_next;
    logic [7:0] awaddr_reg, awaddr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic wstrb0_reg, wstrb0_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;

    // Read channel state
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic arready_reg, arready_next;

    // Control output state
    logic field_reg, field_next;
    omc_pkg::omc_ctl_t ctl_reg, ctl_next;
    omc_pkg::omc_proto_t proto_reg, proto_next;
    logic pm_reg, pm_next;

    // Decoded helpers
    logic do_write;
    logic field_off_seen;
    omc_pkg::omc_proto_t proto_dec;

    // Role and code to protocol
    function automatic omc_pkg::omc_proto_t decode_mode(input logic target, input logic [3:0] code);
        omc_pkg::omc_proto_t p;
        p = omc_pkg::OMC_PROTO_NONE;
        if (target) begin
            unique case (code)
                `OMC_T_P2P_DET: p = omc_pkg::OMC_PROTO_T_P2P_DET;
                `OMC_T_P2P_NORM: p = omc_pkg::OMC_PROTO_T_P2P_NORM;
                default: p = omc_pkg::OMC_PROTO_NONE;
            endcase
        end else begin
            unique case (code)
                `OMC_I_P2P: p = omc_pkg::OMC_PROTO_I_P2P;
                `OMC_I_TYPE_A: p = omc_pkg::OMC_PROTO_I_TYPE_A;
                `OMC_I_TYPE_B: p = omc_pkg::OMC_PROTO_I_TYPE_B;
                `OMC_I_TYPE_F: p = omc_pkg::OMC_PROTO_I_TYPE_F;
                `OMC_I_TYPE_1: p = omc_pkg::OMC_PROTO_I_TYPE_1;
                `OMC_I_SUBC: p = omc_pkg::OMC_PROTO_I_SUBC;
                `OMC_I_BPSK: p = omc_pkg::OMC_PROTO_I_BPSK;
                default: p = omc_pkg::OMC_PROTO_NONE;
            endcase
        end
        return p;
    endfunction

    // Active communication modes clear transmit after a frame
    function automatic logic is_active_mode(input omc_pkg::omc_proto_t p);
        return (p == omc_pkg::OMC_PROTO_I_P2P) || (p == omc_pkg::OMC_PROTO_T_P2P_DET) ||
               (p == omc_pkg::OMC_PROTO_T_P2P_NORM);
    endfunction

    // Write channel capture and register update
    always_comb begin
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb0_next = wstrb0_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        op_next = op_reg;
        md_next = md_reg;
        // Address phase, refused while a response waits
        if (S_AXI_AWVALID && !aw_got_reg && !bvalid_reg) begin
            aw_got_next = 1'b1;
            awaddr_next = S_AXI_AWADDR;
        end
        // Data phase, low byte lane only
        if (S_AXI_WVALID && !w_got_reg && !bvalid_reg) begin
            w_got_next = 1'b1;
            wdata_next = S_AXI_WDATA[7:0];
            wstrb0_next = S_AXI_WSTRB[0];
        end
        do_write = aw_got_reg && w_got_reg && !bvalid_reg;
        proto_dec = decode_mode(md_reg[`OMC_MD_TARGET], md_reg[`OMC_MD_CODE_HI:`OMC_MD_CODE_LO]);
        // Hardware clear of transmit, then software write, then field-on set
        if (TX_DONE && is_active_mode(proto_dec)) begin
            op_next[`OMC_OP_TX_EN] = 1'b0;
        end
        if (do_write) begin
            aw_got_next = 1'b0;
            w_got_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = `OMC_RESP_OKAY;
            unique case (awaddr_reg)
                `OMC_ADDR_OPCTL: begin
                    if (wstrb0_reg) begin
                        op_next = wdata_reg & `OMC_OP_MASK;
                    end
                end
                `OMC_ADDR_MODE: begin
                    if (wstrb0_reg) begin
                        md_next = wdata_reg & `OMC_MD_MASK;
                    end
                end
                `OMC_ADDR_EVENT: begin
                    if (wstrb0_reg && wdata_reg[`OMC_EV_SET_DEFAULT]) begin
                        md_next = `OMC_MD_RESET;
                    end
                    if (wstrb0_reg && wdata_reg[`OMC_EV_FIELD_ON]) begin
                        op_next[`OMC_OP_TX_EN] = 1'b1;
                    end
                end
                `OMC_ADDR_STATUS: bresp_next = `OMC_RESP_OKAY;
                default: bresp_next = `OMC_RESP_SLVERR;
            endcase
        end
        if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_next = 1'b0;
        end
        // Ready flags registered so the bus sees flop outputs
        awready_next = !aw_got_next && !bvalid_next;
        wready_next = !w_got_next && !bvalid_next;
    end

    // Read channel
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (S_AXI_ARVALID && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next = `OMC_RESP_OKAY;
            unique case (S_AXI_ARADDR)
                `OMC_ADDR_OPCTL: rdata_next = {24'h000000, op_reg};
                `OMC_ADDR_MODE: rdata_next = {24'h000000, md_reg};
                `OMC_ADDR_EVENT: rdata_next = 32'h00000000;
                `OMC_ADDR_STATUS: rdata_next = {27'h0000000, ctl_reg.mode_supported, proto_reg};
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = `OMC_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && S_AXI_RREADY) begin
            rvalid_next = 1'b0;
        end
        // Address ready again once the data is taken
        arready_next = !rvalid_next;
    end

    // Control outputs from the registers and the field and channel pick inputs
    always_comb begin
        logic ok;
        ok = (proto_dec != omc_pkg::OMC_PROTO_NONE);
        field_next = EXT_FIELD_ON;
        field_off_seen = field_reg && !EXT_FIELD_ON;
        proto_next = proto_dec;
        ctl_next.osc_ready = op_reg[`OMC_OP_READY];
        ctl_next.rx_enable = op_reg[`OMC_OP_RX_EN] && ok;
        ctl_next.tx_enable = op_reg[`OMC_OP_TX_EN] && ok;
        ctl_next.single_channel = op_reg[`OMC_OP_ONE_CHN];
        ctl_next.manual_pick = !op_reg[`OMC_OP_ONE_CHN] && op_reg[`OMC_OP_MAN_SEL];
        ctl_next.auto_pick = !op_reg[`OMC_OP_ONE_CHN] && !op_reg[`OMC_OP_MAN_SEL];
        ctl_next.wake_mode_on = op_reg[`OMC_OP_WAKE];
        ctl_next.target_role = md_reg[`OMC_MD_TARGET];
        ctl_next.auto_response_collision_avoid = md_reg[`OMC_MD_AUTO_CA];
        ctl_next.start_collision_avoid = md_reg[`OMC_MD_AUTO_CA] && field_off_seen;
        ctl_next.mode_supported = ok;
        // Channel used when the pick is not automatic
        pm_next = CHANNEL_PICK_BIT;
    end

    // Write channel and register state
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            op_reg <= `OMC_OP_RESET;
            md_reg <= `OMC_MD_RESET;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `OMC_RESP_OKAY;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
        end else begin
            op_reg <= op_next;
            md_reg <= md_next;
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb0_reg <= wstrb0_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
        end
    end

    // Read channel state
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `OMC_RESP_OKAY;
            arready_reg <= 1'b1;
        end else begin
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            arready_reg <= arready_next;
        end
    end

    // Control output state
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            field_reg <= 1'b0;
            ctl_reg <= '0;
            proto_reg <= omc_pkg::OMC_PROTO_NONE;
            pm_reg <= 1'b0;
        end else begin
            field_reg <= field_next;
            ctl_reg <= ctl_next;
            proto_reg <= proto_next;
            pm_reg <= pm_next;
        end
    end

    // Bus handshake outputs, all straight from flops
    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY = wready_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;
    assign CTL = ctl_reg;
    assign PROTO = proto_reg;
    assign RX_USE_PM = pm_reg;

endmodule // omc_ctrl
`default_nettype wire

// ==== hw/omc_map.svh ====
`ifndef OMC_MAP_SVH
`define OMC_MAP_SVH

// Byte addresses of the registers on the AXI4-Lite bus
`define OMC_ADDR_OPCTL 8'h08
`define OMC_ADDR_MODE 8'h0c
`define OMC_ADDR_EVENT 8'h10
`define OMC_ADDR_STATUS 8'h14

// Printed register indices
`define OMC_IDX_OPCTL 8'h02
`define OMC_IDX_MODE 8'h03

// Operation control fields
`define OMC_OP_READY 7
`define OMC_OP_RX_EN 6
`define OMC_OP_ONE_CHN 5
`define OMC_OP_MAN_SEL 4
`define OMC_OP_TX_EN 3
`define OMC_OP_WAKE 2
`define OMC_OP_MASK 8'hfc
`define OMC_OP_RESET 8'h00

// Mode definition fields
`define OMC_MD_TARGET 7
`define OMC_MD_CODE_HI 6
`define OMC_MD_CODE_LO 3
`define OMC_MD_AUTO_CA 0
`define OMC_MD_MASK 8'hf9
`define OMC_MD_RESET 8'h08

// Event register bits, write one to fire
`define OMC_EV_SET_DEFAULT 0
`define OMC_EV_FIELD_ON 1

// Protocol codes, initiator role
`define OMC_I_P2P 4'h0
`define OMC_I_TYPE_A 4'h1
`define OMC_I_TYPE_B 4'h2
`define OMC_I_TYPE_F 4'h3
`define OMC_I_TYPE_1 4'h4
`define OMC_I_SUBC 4'he
`define OMC_I_BPSK 4'hf

// Protocol codes, target role
`define OMC_T_P2P_DET 4'h0
`define OMC_T_P2P_NORM 4'h1

// Bus responses
`define OMC_RESP_OKAY 2'h0
`define OMC_RESP_SLVERR 2'h2

`endif

// ==== hw/omc_pkg.sv ====
`default_nettype none
package omc_pkg;

    // Decoded protocol selection
    typedef enum logic [3:0] {
        OMC_PROTO_NONE,
        OMC_PROTO_I_P2P,
        OMC_PROTO_I_TYPE_A,
        OMC_PROTO_I_TYPE_B,
        OMC_PROTO_I_TYPE_F,
        OMC_PROTO_I_TYPE_1,
        OMC_PROTO_I_SUBC,
        OMC_PROTO_I_BPSK,
        OMC_PROTO_T_P2P_DET,
        OMC_PROTO_T_P2P_NORM
    } omc_proto_t;

    // Control outputs towards the analog front end and framing
    typedef struct packed {
        logic osc_ready;
        logic rx_enable;
        logic single_channel;
        logic manual_pick;
        logic auto_pick;
        logic tx_enable;
        logic wake_mode_on;
        logic target_role;
        logic auto_response_collision_avoid;
        logic start_collision_avoid;
        logic mode_supported;
    } omc_ctl_t;

endpackage
`default_nettype wire

// ==== testbench/omc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module omc_chk (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Read side
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    // Core and control
    input wire logic EXT_FIELD_ON,
    input wire omc_pkg::omc_ctl_t CTL,
    input wire omc_pkg::omc_proto_t PROTO
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // Paths gated by mode support
    AST_RX_GATE: assert property (CTL.rx_enable |-> CTL.mode_supported)
        else $error("rx on in bad mode");
    AST_TX_GATE: assert property (CTL.tx_enable |-> CTL.mode_supported)
        else $error("tx on in bad mode");
    AST_MODE_OK: assert property (CTL.mode_supported == (PROTO != omc_pkg::OMC_PROTO_NONE))
        else $error("support flag mismatch");
    // Channel pick method
    AST_PICK: assert property (CTL.auto_pick |-> !CTL.single_channel && !CTL.manual_pick)
        else $error("auto pick with other method");
    // Role decides code reading
    AST_ROLE_T: assert property (PROTO >= omc_pkg::OMC_PROTO_T_P2P_DET |-> CTL.target_role)
        else $error("target code in initiator role");
    AST_ROLE_I: assert property (CTL.target_role |-> PROTO < omc_pkg::OMC_PROTO_I_P2P || PROTO > 4'h7)
        else $error("initiator code in target role");
    // Collision avoidance start
    AST_CA_SRC: assert property (CTL.start_collision_avoid |-> CTL.auto_response_collision_avoid)
        else $error("start without enable");
    AST_CA_PULSE: assert property (CTL.start_collision_avoid |=> !CTL.start_collision_avoid)
        else $error("start longer than a pulse");
    // Start only right after the field was seen going off
    AST_CA_EDGE: assert property (CTL.start_collision_avoid
        |-> $past(EXT_FIELD_ON, 2) && !$past(EXT_FIELD_ON))
        else $error("start without field off");
    // Read answer one cycle after address
    AST_RD_LAT: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
endmodule // omc_chk
`default_nettype wire

// ==== testbench/omc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module omc_host (
    // Clock
    input wire logic CLK,
    // Write channels
    output logic [7:0] S_AXI_AWADDR,
    output logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    output logic [31:0] S_AXI_WDATA,
    output logic [3:0] S_AXI_WSTRB,
    output logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    output logic S_AXI_BREADY,
    // Read channels
    output logic [7:0] S_AXI_ARADDR,
    output logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    output logic S_AXI_RREADY
);
    // Idle bus, low byte lane only
    initial {S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WVALID, S_AXI_BREADY} = '0;
    initial {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY, S_AXI_WSTRB} = 14'h0001;
    // One write, each channel dropped after its own take
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        logic ta;
        logic tw;
        logic tb;
        @(posedge CLK);
        S_AXI_AWADDR <= a;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WDATA <= {24'h000000, d};
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            @(negedge CLK);
            ta = S_AXI_AWVALID && S_AXI_AWREADY;
            tw = S_AXI_WVALID && S_AXI_WREADY;
            tb = S_AXI_BVALID;
            r = S_AXI_BRESP;
            @(posedge CLK);
            if (ta) S_AXI_AWVALID <= 1'b0;
            if (tw) S_AXI_WVALID <= 1'b0;
        end while (!tb);
        S_AXI_BREADY <= 1'b0;
    endtask
    // One read
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta;
        logic tv;
        @(posedge CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(negedge CLK);
            ta = S_AXI_ARVALID && S_AXI_ARREADY;
            tv = S_AXI_RVALID;
            d = S_AXI_RDATA;
            r = S_AXI_RRESP;
            @(posedge CLK);
            if (ta) S_AXI_ARVALID <= 1'b0;
        end while (!tv);
        S_AXI_RREADY <= 1'b0;
    endtask
endmodule // omc_host
`default_nettype wire

// ==== testbench/omc_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "omc_map.svh"
module operation_and_mode_control_bench;
    // Clock, reset and core events
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    logic TX_DONE = 1'b0;
    logic EXT_FIELD_ON = 1'b0;
    logic CHANNEL_PICK_BIT = 1'b0;
    wire logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
    wire logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
    wire logic [3:0] S_AXI_WSTRB;
    wire logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    wire logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
    wire logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    omc_pkg::omc_ctl_t CTL;
    omc_pkg::omc_proto_t PROTO;
    logic RX_USE_PM;
    int fails = 0;
    int checks_done = 0;
    logic [31:0] rd_v;
    logic [1:0] rsp;
    always #4 CLK = ~CLK;
    omc_host host (.CLK, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
        .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
        .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
    omc_ctrl dut (.CLK, .RSTN, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
        .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
        .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
        .TX_DONE, .EXT_FIELD_ON, .CHANNEL_PICK_BIT, .CTL, .PROTO, .RX_USE_PM);
    // Compare and count
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        host.rd(a, rd_v, rsp);
        chk("rdata", e, rd_v);
        chk("rresp", `OMC_RESP_OKAY, rsp);
    endtask
    // Write, then let the control outputs follow
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d, rsp);
        chk("bresp", `OMC_RESP_OKAY, rsp);
        repeat (2) @(negedge CLK);
    endtask
    task automatic txp;
        @(posedge CLK) TX_DONE <= 1'b1;
        @(posedge CLK) TX_DONE <= 1'b0;
        repeat (2) @(negedge CLK);
    endtask
    // Expected status: supported flag and decoded protocol
    function automatic logic [4:0] stat(input logic t, input logic [3:0] c);
        if (t) return (c == 4'h0) ? 5'h18 : (c == 4'h1) ? 5'h19 : 5'h00;
        if (c <= 4'h4) return {1'b1, c + 4'h1};
        return (c == 4'he) ? 5'h16 : (c == 4'hf) ? 5'h17 : 5'h00;
    endfunction
    // Reset values, unused bits, control bits
    task automatic t_regs;
        rchk(`OMC_ADDR_OPCTL, 32'h00);
        rchk(`OMC_ADDR_MODE, 32'h08);
        put(`OMC_ADDR_OPCTL, 8'hff);
        rchk(`OMC_ADDR_OPCTL, 32'hfc);
        chk("ready_rx", 2'h3, {CTL.osc_ready, CTL.rx_enable});
        chk("chn_tx_wake", 3'h7, {CTL.single_channel, CTL.tx_enable, CTL.wake_mode_on});
        put(`OMC_ADDR_OPCTL, 8'h50);
        chk("pick", 3'h2, {CTL.single_channel, CTL.manual_pick, CTL.auto_pick});
        put(`OMC_ADDR_OPCTL, 8'h40);
        chk("pick", 3'h1, {CTL.single_channel, CTL.manual_pick, CTL.auto_pick});
    endtask
    // Every role and code
    task automatic t_modes;
        logic [4:0] s;
        put(`OMC_ADDR_OPCTL, 8'h48);
        for (int i = 0; i < 32; i++) begin
            s = stat(i[4], i[3:0]);
            put(`OMC_ADDR_MODE, {i[4], i[3:0], 3'h0});
            rchk(`OMC_ADDR_STATUS, {27'h0, s});
            chk("proto", s[3:0], PROTO);
            chk("role", i[4], CTL.target_role);
            chk("gate", {2{s[4]}}, {CTL.rx_enable, CTL.tx_enable});
        end
        put(`OMC_ADDR_MODE, 8'hff);
        rchk(`OMC_ADDR_MODE, 32'hf9);
    endtask
    // Set-default, field-on, end of transmission
    task automatic t_events;
        put(`OMC_ADDR_MODE, 8'h81);
        put(`OMC_ADDR_OPCTL, 8'h80);
        put(`OMC_ADDR_EVENT, 8'h01);
        rchk(`OMC_ADDR_MODE, 32'h08);
        rchk(`OMC_ADDR_OPCTL, 32'h80);
        put(`OMC_ADDR_EVENT, 8'h02);
        rchk(`OMC_ADDR_OPCTL, 32'h88);
        put(`OMC_ADDR_MODE, 8'h00);
        txp;
        rchk(`OMC_ADDR_OPCTL, 32'h80);
        put(`OMC_ADDR_MODE, 8'h08);
        put(`OMC_ADDR_OPCTL, 8'h88);
        txp;
        rchk(`OMC_ADDR_OPCTL, 32'h88);
    endtask
    // Field going off, with and without auto start
    task automatic t_ca;
        int n;
        for (int a = 0; a < 2; a++) begin
            n = 0;
            put(`OMC_ADDR_MODE, {7'h04, a[0]});
            chk("ca_en", a, CTL.auto_response_collision_avoid);
            @(posedge CLK) EXT_FIELD_ON <= 1'b1;
            repeat (3) @(posedge CLK);
            EXT_FIELD_ON <= 1'b0;
            repeat (6) @(negedge CLK) if (CTL.start_collision_avoid === 1'b1) n++;
            chk("ca", a, n);
        end
    endtask
    // Unmapped place and channel pick input
    task automatic t_misc;
        host.wr(8'h20, 8'h55, rsp);
        chk("bresp", `OMC_RESP_SLVERR, rsp);
        host.rd(8'h20, rd_v, rsp);
        chk("rresp", `OMC_RESP_SLVERR, rsp);
        chk("use_pm", 0, RX_USE_PM);
        @(posedge CLK) CHANNEL_PICK_BIT <= 1'b1;
        repeat (2) @(negedge CLK);
        chk("use_pm", 1, RX_USE_PM);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge CLK);
        RSTN <= 1'b1;
        t_regs;
        t_modes;
        t_events;
        t_ca;
        t_misc;
        final_report;
    end
    // Watchdog
    initial begin
        #300000;
        fails++;
        final_report;
    end
endmodule // operation_and_mode_control_bench
bind omc_ctrl omc_chk chk (.CLK, .RSTN, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .EXT_FIELD_ON, .CTL, .PROTO);
`default_nettype wire
